// ===== irda_ctrl_defines.svh
// constants of the infrared port control block: offsets, fields, resets, timing
// assumes inclusion by the package, by the design modules and by the bench
`ifndef IRDA_CTRL_DEFINES_SVH
`define IRDA_CTRL_DEFINES_SVH

// register indices, byte address is four times the index
`define IDX_DIV_LOW 3'h0
`define IDX_DIV_HIGH 3'h1
`define IDX_CONTROL_ONE 3'h2
`define IDX_BANK 3'h3
`define IDX_HANDSHAKE 3'h4
`define IDX_STATUS5 3'h5
`define IDX_FILL_TX 3'h6
`define IDX_FRAME_STATUS 3'h7

// bank select codes
`define BANK_CODE_SET2 8'hE0
`define BANK_CODE_SET3 8'hE4
`define BANK_CODE_SET4 8'hE8
`define BANK_CODE_SET5 8'hEC
`define BANK_CODE_SET6 8'hF0
`define BANK_CODE_SET7 8'hF4
`define BANK_RESET 8'hE0
`define SET2_BANK_READ 8'hE0

// reset values
`define CONTROL_ONE_RESET 8'h00
`define CONTROL_TWO_RESET 8'h00
`define HANDSHAKE_RESET 8'h60
`define FRAME_STATUS_RESET 8'h00

// control one fields
`define C1_BAUD_OUT 7
`define C1_LOOP_PIN 5
`define C1_ALL_LOOP 4
`define C1_CH_SWAP 3
`define C1_DMA_THR 2
`define C1_FAIR 1
`define C1_ADV_SEL 0
// control two and handshake fields
`define C2_FALLBACK_DIS 7
`define HS_MODE_HI 7
`define HS_MODE_LO 5
`define HS_LEGACY_LOOP 4
`define HS_DMA_EN 2
`define HS_DTR 0

// advanced mode codes
`define MODE_MIR_LOW 3'h1
`define MODE_MIR_HIGH 3'h4
`define MODE_FIR 3'h5
`define MODE_REMOTE 3'h6

// dma thresholds
`define TX_THR_LOW 5'h0D
`define TX_THR_HIGH_16 5'h17
`define TX_THR_HIGH_32 5'h07
`define RX_THR_LOW 4'h4
`define RX_THR_HIGH 4'hA
`define FIFO_SIZE_32 2'h1

// timing
`define CLK_SYS_MHZ 200
`define FAIRNESS_TIME_NS 10500

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== irda_ctrl_pkg.sv
// types of the infrared port control block
// assumes the defines header is on the include path
`include "irda_ctrl_defines.svh"
package irda_ctrl_pkg;

	typedef struct packed {
		logic flow_control;
		logic tx_empty;
		logic terminal_count;
		logic frame_end_taken;
		logic receiver_busy;
		logic frame_end_lost;
		logic remote_pulse;
		logic frame_end_in_fifo;
		logic rx_data_timeout;
		logic frame_status_timeout;
	} ir_events_type;

	typedef struct packed {
		logic [15:0] divisor;
		logic [7:0] control_one;
		logic [7:0] control_two;
		logic [7:0] handshake;
		logic [7:0] ir_control;
		logic [7:0] scratch;
		logic [1:0] set4_bits;
		logic [7:0] bank_select;
	} regs_type;

	typedef struct packed {
		logic flow_control_active;
		logic tx_underrun_flag;
		logic lost_frame_end;
		logic remote_pulse_seen;
		logic frame_end_request;
		logic receive_timeout_flag;
	} flags_type;

	typedef struct packed {
		logic aw_held;
		logic aw_bad;
		logic [2:0] aw_index;
		logic w_held;
		logic [7:0] w_data;
		logic w_lane0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} bus_type;

	typedef struct packed {
		regs_type regs;
		flags_type flags;
		bus_type bus;
		logic ir_tx_pin;
		logic dtr_pin;
	} ctrl_state_type;

	typedef struct packed {
		logic [11:0] count;
		logic blocked;
	} fair_state_type;

	// bank value to register set number
	function automatic logic [2:0] set_of(input logic [7:0] v);
		logic [2:0] s;
		s = 3'h1;
		if (!v[7]) begin
			s = 3'h0;
		end else begin
			unique case (v)
				`BANK_CODE_SET2: s = 3'h2;
				`BANK_CODE_SET3: s = 3'h3;
				`BANK_CODE_SET4: s = 3'h4;
				`BANK_CODE_SET5: s = 3'h5;
				`BANK_CODE_SET6: s = 3'h6;
				`BANK_CODE_SET7: s = 3'h7;
				default: s = 3'h1;
			endcase
		end
		return s;
	endfunction

endpackage

// ===== dma_fairness_gate.sv
// dma request gate that drops a request held too long
// assumes the raw request comes from logic on CLK_SYS
`timescale 1ns/1ps
`include "irda_ctrl_defines.svh"
module dma_fairness_gate import irda_ctrl_pkg::*; (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// control
	input wire logic limit_enable,
	// request
	input wire logic request_raw,
	output logic request_out
);

	localparam int FAIR_CYCLES = (`FAIRNESS_TIME_NS * `CLK_SYS_MHZ + 999) / 1000;
	localparam logic [11:0] FAIR_LAST = 12'(FAIR_CYCLES - 1);

	fair_state_type s_reg;
	fair_state_type s_next;

	always_comb begin
		s_next = s_reg;
		if (!request_raw) begin
			s_next.count = 12'h000;
			s_next.blocked = 1'b0;
		end else if (limit_enable && !s_reg.blocked) begin
			if (s_reg.count == FAIR_LAST) begin
				s_next.blocked = 1'b1;
			end else begin
				s_next.count = s_reg.count + 12'h001;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// held request is cut only while fairness limiting is on
	assign request_out = request_raw && !(limit_enable && s_reg.blocked);

endmodule

// ===== infrared_uart_advanced_control.sv
// banked control and status registers of an infrared serial port, axi4-lite slave
// assumes event inputs and fill levels come from logic on CLK_SYS
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "irda_ctrl_defines.svh"
module infrared_uart_advanced_control import irda_ctrl_pkg::*; (
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RST,
	// axi4-lite write address
	input wire logic [31:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	// axi4-lite write data
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	// axi4-lite write response
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	// axi4-lite read address
	input wire logic [31:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	// axi4-lite read data
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	// receiver and transmitter events
	input wire ir_events_type EVENTS,
	input wire logic [5:0] TX_FILL_LEVEL,
	input wire logic [5:0] RX_FILL_LEVEL,
	// serial data and baud clock
	input wire logic BAUD_CLOCK,
	input wire logic TX_SERIAL_DATA,
	// dma requests from the fifos
	input wire logic RX_DMA_WANT,
	input wire logic TX_DMA_WANT,
	// pins
	output logic IR_TX_PIN,
	output logic DTR_PIN,
	// dma
	output logic DMA_REQUEST,
	output logic DMA_SERVES_TX,
	output logic [4:0] TX_DMA_THRESHOLD,
	output logic [3:0] RX_DMA_THRESHOLD,
	// mode and control
	output logic ADVANCED_MODE,
	output logic [2:0] MODE_CODE,
	output logic LOOPBACK_ACTIVE,
	output logic FRAME_END_REQUEST,
	output logic [15:0] DIVISOR,
	output logic [1:0] SET4_CONTROL
);

	ctrl_state_type s_reg;
	ctrl_state_type s_next;

	logic advanced;
	logic fast_mode;
	logic remote_mode;
	logic dma_enabled;
	logic loop_on;
	logic [2:0] cur_set;
	logic aw_take;
	logic w_take;
	logic ar_take;
	logic do_write;
	logic rd_bad;
	logic [2:0] rd_index;
	logic dma_want;

	assign advanced = s_reg.regs.control_one[`C1_ADV_SEL];
	assign MODE_CODE = s_reg.regs.handshake[`HS_MODE_HI:`HS_MODE_LO];
	assign fast_mode = advanced && (MODE_CODE == `MODE_MIR_LOW || MODE_CODE == `MODE_MIR_HIGH
		|| MODE_CODE == `MODE_FIR);
	assign remote_mode = advanced && (MODE_CODE == `MODE_REMOTE);
	assign dma_enabled = s_reg.regs.handshake[`HS_DMA_EN];
	assign cur_set = set_of(s_reg.regs.bank_select);
	// legacy diagnostic loop or all mode loop
	assign loop_on = (!advanced && s_reg.regs.handshake[`HS_LEGACY_LOOP])
		|| s_reg.regs.control_one[`C1_ALL_LOOP];

	// axi handshakes: one write and one read in flight at a time
	assign aw_take = S_AXI_AWVALID && !s_reg.bus.aw_held && !s_reg.bus.bvalid;
	assign w_take = S_AXI_WVALID && !s_reg.bus.w_held && !s_reg.bus.bvalid;
	assign ar_take = S_AXI_ARVALID && !s_reg.bus.rvalid;
	assign do_write = s_reg.bus.aw_held && s_reg.bus.w_held;
	assign rd_bad = |S_AXI_ARADDR[31:5];
	assign rd_index = S_AXI_ARADDR[4:2];

	assign S_AXI_AWREADY = !s_reg.bus.aw_held && !s_reg.bus.bvalid;
	assign S_AXI_WREADY = !s_reg.bus.w_held && !s_reg.bus.bvalid;
	assign S_AXI_ARREADY = !s_reg.bus.rvalid;
	assign S_AXI_BVALID = s_reg.bus.bvalid;
	assign S_AXI_BRESP = s_reg.bus.bresp;
	assign S_AXI_RVALID = s_reg.bus.rvalid;
	assign S_AXI_RRESP = s_reg.bus.rresp;
	assign S_AXI_RDATA = s_reg.bus.rdata;

	// status byte of offset 7 in advanced mode
	function automatic logic [7:0] status_byte(input ctrl_state_type st, input logic fast,
		input logic remote, input ir_events_type ev);
		logic [7:0] b;
		b = 8'h00;
		b[7] = st.flags.flow_control_active;
		b[6] = st.flags.tx_underrun_flag;
		b[5] = (fast || remote) && ev.receiver_busy;
		b[4] = fast ? st.flags.lost_frame_end : (remote && st.flags.remote_pulse_seen);
		b[3] = st.flags.frame_end_request;
		b[1] = ev.frame_end_in_fifo;
		b[0] = st.flags.receive_timeout_flag;
		return b;
	endfunction

	always_comb begin
		logic [7:0] rbyte;
		logic rd_fallback;
		logic wr_fallback;
		logic fallback_hit;
		logic [2:0] wi;
		logic [7:0] wd;
		rbyte = 8'h00;
		rd_fallback = 1'b0;
		wr_fallback = 1'b0;
		fallback_hit = 1'b0;
		wi = s_reg.bus.aw_index;
		wd = s_reg.bus.w_data;
		s_next = s_reg;

		// address and data may arrive in either order
		if (aw_take) begin
			s_next.bus.aw_held = 1'b1;
			s_next.bus.aw_bad = |S_AXI_AWADDR[31:5];
			s_next.bus.aw_index = S_AXI_AWADDR[4:2];
		end
		if (w_take) begin
			s_next.bus.w_held = 1'b1;
			s_next.bus.w_data = S_AXI_WDATA[7:0];
			s_next.bus.w_lane0 = S_AXI_WSTRB[0];
		end
		if (s_reg.bus.bvalid && S_AXI_BREADY) begin
			s_next.bus.bvalid = 1'b0;
		end
		if (s_reg.bus.rvalid && S_AXI_RREADY) begin
			s_next.bus.rvalid = 1'b0;
		end

		// transmitter has consumed the frame end
		if (EVENTS.frame_end_taken) begin
			s_next.flags.frame_end_request = 1'b0;
		end

		// read path with its side effects
		if (ar_take) begin
			s_next.bus.rvalid = 1'b1;
			s_next.bus.rresp = rd_bad ? `RESP_SLVERR : `RESP_OKAY;
			if (!rd_bad) begin
				unique case (rd_index)
					`IDX_DIV_LOW: begin
						if (cur_set == 3'h1 || cur_set == 3'h2) begin
							rbyte = s_reg.regs.divisor[7:0];
						end
						rd_fallback = (cur_set == 3'h1);
					end
					`IDX_DIV_HIGH: begin
						if (cur_set == 3'h1 || cur_set == 3'h2) begin
							rbyte = s_reg.regs.divisor[15:8];
						end
						rd_fallback = (cur_set == 3'h1);
					end
					`IDX_CONTROL_ONE: begin
						if (cur_set == 3'h2) begin
							rbyte = s_reg.regs.control_one;
						end
					end
					`IDX_BANK: begin
						if (cur_set == 3'h2) begin
							rbyte = `SET2_BANK_READ;
						end else if (cur_set <= 3'h1) begin
							rbyte = s_reg.regs.ir_control;
						end
					end
					`IDX_HANDSHAKE: begin
						if (cur_set == 3'h2) begin
							rbyte = s_reg.regs.control_two;
						end else if (cur_set <= 3'h1) begin
							rbyte = s_reg.regs.handshake;
						end
					end
					`IDX_STATUS5: begin
						rbyte = 8'h00;
					end
					`IDX_FILL_TX: begin
						if (cur_set == 3'h2) begin
							rbyte = {2'h0, TX_FILL_LEVEL};
						end
					end
					`IDX_FRAME_STATUS: begin
						if (cur_set == 3'h2) begin
							rbyte = {2'h0, RX_FILL_LEVEL};
						end else if (cur_set <= 3'h1) begin
							if (advanced) begin
								rbyte = status_byte(s_reg, fast_mode, remote_mode, EVENTS);
								// cleared only by this read strobe
								s_next.flags.flow_control_active = 1'b0;
								s_next.flags.lost_frame_end = 1'b0;
								s_next.flags.remote_pulse_seen = 1'b0;
								s_next.flags.receive_timeout_flag = 1'b0;
							end else begin
								rbyte = s_reg.regs.scratch;
							end
						end
					end
				endcase
			end
			s_next.bus.rdata = {24'h000000, rbyte};
		end

		// write path once address and data are both held
		if (do_write) begin
			s_next.bus.aw_held = 1'b0;
			s_next.bus.w_held = 1'b0;
			s_next.bus.bvalid = 1'b1;
			s_next.bus.bresp = s_reg.bus.aw_bad ? `RESP_SLVERR : `RESP_OKAY;
			if (!s_reg.bus.aw_bad && s_reg.bus.w_lane0) begin
				unique case (wi)
					`IDX_DIV_LOW: begin
						if (cur_set == 3'h1 || cur_set == 3'h2) begin
							s_next.regs.divisor[7:0] = wd;
						end
						wr_fallback = (cur_set == 3'h1);
					end
					`IDX_DIV_HIGH: begin
						if (cur_set == 3'h1 || cur_set == 3'h2) begin
							s_next.regs.divisor[15:8] = wd;
						end
						wr_fallback = (cur_set == 3'h1);
					end
					`IDX_CONTROL_ONE: begin
						if (cur_set == 3'h2) begin
							s_next.regs.control_one = {wd[7], 1'b0, wd[5:0]};
						end
					end
					`IDX_BANK: begin
						s_next.regs.bank_select = wd;
						if (cur_set <= 3'h1) begin
							s_next.regs.ir_control = wd;
						end
						if (cur_set == 3'h4) begin
							s_next.regs.set4_bits = wd[3:2];
						end
					end
					`IDX_HANDSHAKE: begin
						if (cur_set == 3'h2) begin
							s_next.regs.control_two = {wd[7], 1'b0, wd[5:0]};
						end else if (cur_set <= 3'h1) begin
							s_next.regs.handshake = wd;
						end
					end
					`IDX_STATUS5: begin
						s_next.regs.scratch = s_reg.regs.scratch;
					end
					`IDX_FILL_TX: begin
						s_next.regs.scratch = s_reg.regs.scratch;
					end
					`IDX_FRAME_STATUS: begin
						if (cur_set <= 3'h1) begin
							if (advanced) begin
								if (wd[6]) begin
									s_next.flags.tx_underrun_flag = 1'b0;
								end
								s_next.flags.frame_end_request = wd[3];
							end else begin
								s_next.regs.scratch = wd;
							end
						end
					end
				endcase
			end
		end

		// legacy divisor access: fall back unless disabled
		fallback_hit = rd_fallback || wr_fallback;
		if (fallback_hit && !s_reg.regs.control_two[`C2_FALLBACK_DIS]) begin
			if (advanced) begin
				s_next.regs.handshake[`HS_MODE_HI:`HS_MODE_LO] = 3'h0;
				s_next.regs.control_one[`C1_ADV_SEL] = 1'b0;
				s_next.regs.control_one[`C1_LOOP_PIN] = 1'b0;
				s_next.regs.control_one[`C1_BAUD_OUT] = 1'b0;
				s_next.regs.set4_bits = 2'h0;
			end else begin
				s_next.regs.control_one[`C1_LOOP_PIN] = 1'b0;
				s_next.regs.control_one[`C1_BAUD_OUT] = 1'b0;
			end
		end
		// with fallback disabled nothing else is touched here
		if (fallback_hit && s_reg.regs.control_two[`C2_FALLBACK_DIS]) begin
			s_next.regs.handshake = s_next.regs.handshake;
		end

		// events last so that a set wins over a same-cycle clear
		if (fast_mode && EVENTS.flow_control) begin
			s_next.flags.flow_control_active = 1'b1;
		end
		if (fast_mode && EVENTS.tx_empty
			&& (dma_enabled ? !EVENTS.terminal_count : !s_reg.flags.frame_end_request)) begin
			s_next.flags.tx_underrun_flag = 1'b1;
		end
		if (fast_mode && EVENTS.frame_end_lost) begin
			s_next.flags.lost_frame_end = 1'b1;
		end
		if (remote_mode && EVENTS.remote_pulse) begin
			s_next.flags.remote_pulse_seen = 1'b1;
		end
		if ((fast_mode || remote_mode)
			&& (EVENTS.rx_data_timeout || EVENTS.frame_status_timeout)) begin
			s_next.flags.receive_timeout_flag = 1'b1;
		end

		// pin drivers
		if (loop_on && !s_reg.regs.control_one[`C1_LOOP_PIN]) begin
			s_next.ir_tx_pin = 1'b0;
		end else begin
			s_next.ir_tx_pin = TX_SERIAL_DATA;
		end
		if (s_reg.regs.control_one[`C1_BAUD_OUT]) begin
			s_next.dtr_pin = BAUD_CLOCK;
		end else begin
			s_next.dtr_pin = s_reg.regs.handshake[`HS_DTR];
		end
	end

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			s_reg <= '0;
			s_reg.regs.control_one <= `CONTROL_ONE_RESET;
			s_reg.regs.control_two <= `CONTROL_TWO_RESET;
			s_reg.regs.handshake <= `HANDSHAKE_RESET;
			s_reg.regs.bank_select <= `BANK_RESET;
			s_reg.regs.scratch <= `FRAME_STATUS_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	// single dma channel owner
	assign DMA_SERVES_TX = s_reg.regs.control_one[`C1_CH_SWAP];
	assign dma_want = fast_mode && dma_enabled && (DMA_SERVES_TX ? TX_DMA_WANT : RX_DMA_WANT);

	dma_fairness_gate fairness (
		.clk_sys(CLK_SYS),
		.rst(RST),
		.limit_enable(!s_reg.regs.control_one[`C1_FAIR]),
		.request_raw(dma_want),
		.request_out(DMA_REQUEST)
	);

	// dma thresholds by level bit and transmit fifo size
	always_comb begin
		if (!s_reg.regs.control_one[`C1_DMA_THR]) begin
			TX_DMA_THRESHOLD = `TX_THR_LOW;
			RX_DMA_THRESHOLD = `RX_THR_LOW;
		end else begin
			if (s_reg.regs.control_two[1:0] == `FIFO_SIZE_32) begin
				TX_DMA_THRESHOLD = `TX_THR_HIGH_32;
			end else begin
				TX_DMA_THRESHOLD = `TX_THR_HIGH_16;
			end
			RX_DMA_THRESHOLD = `RX_THR_HIGH;
		end
	end

	assign IR_TX_PIN = s_reg.ir_tx_pin;
	assign DTR_PIN = s_reg.dtr_pin;
	assign ADVANCED_MODE = advanced;
	assign LOOPBACK_ACTIVE = loop_on;
	assign FRAME_END_REQUEST = s_reg.flags.frame_end_request;
	assign DIVISOR = s_reg.regs.divisor;
	assign SET4_CONTROL = s_reg.regs.set4_bits;

endmodule

// ===== irda_ctrl_chk.sv
// checker of the infrared port control block, bound to its top module
// assumes one clock domain and the async active-high reset
`timescale 1ns/1ps
module irda_ctrl_chk (
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RST,
	// register bus
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic S_AXI_WVALID,
	input wire logic S_AXI_WREADY,
	input wire logic [1:0] S_AXI_BRESP,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	// pins and control
	input wire logic TX_SERIAL_DATA,
	input wire logic IR_TX_PIN,
	input wire logic LOOPBACK_ACTIVE,
	input wire logic DMA_REQUEST,
	input wire logic ADVANCED_MODE,
	input wire logic [4:0] TX_DMA_THRESHOLD,
	input wire logic [3:0] RX_DMA_THRESHOLD
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	sequence both_taken;
		S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
	endsequence
	sequence write_answer;
		!S_AXI_BVALID ##1 S_AXI_BVALID;
	endsequence
	a_write_answer: assert property (both_taken |=> write_answer)
		else $error("write response late or early");
	a_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY
		|=> S_AXI_BVALID && $stable(S_AXI_BRESP))
		else $error("write response dropped");
	a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read data not one cycle after address");
	a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY
		|=> S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("read data dropped");
	a_rdata_upper: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h000000)
		else $error("upper read bits not zero");
	a_busy_refuse: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
		else $error("write taken while response pending");
	a_read_refuse: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
		else $error("read taken while data pending");
	a_pin_follow: assert property (
		!LOOPBACK_ACTIVE |=> IR_TX_PIN == $past(TX_SERIAL_DATA)) else $error("infrared pin wrong");
	a_thr_pair: assert property (
		(RX_DMA_THRESHOLD == 4'h4) == (TX_DMA_THRESHOLD == 5'h0D)) else $error("thresholds mixed");
	a_dma_legacy: assert property (
		!ADVANCED_MODE |-> !DMA_REQUEST) else $error("dma request in legacy mode");
endmodule

// ===== ir_link_model.sv
// far side of the port: transceiver events, baud clock, serial data, dma wants
// assumes the bench calls hold and fire at clock edges
`timescale 1ns/1ps
module ir_link_model import irda_ctrl_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// link side
	output ir_events_type events,
	output logic baud_clock,
	output logic serial_data,
	output logic rx_want,
	output logic tx_want
);
	logic [9:0] pulse_reg = 10'h000;
	logic [9:0] level_reg = 10'h000;
	logic [3:0] div_reg;
	assign events = ir_events_type'(pulse_reg | level_reg);
	assign baud_clock = div_reg[1];
	assign serial_data = div_reg[0] ^ div_reg[3];
	// fifos always asking for service
	assign rx_want = 1'b1;
	assign tx_want = 1'b1;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div_reg <= 4'h0;
		end else begin
			div_reg <= div_reg + 4'h1;
		end
	end
	task hold(input logic [9:0] v);
		@(posedge clk);
		level_reg <= v;
	endtask
	task fire(input logic [9:0] v);
		@(posedge clk);
		pulse_reg <= v;
		@(posedge clk);
		pulse_reg <= 10'h000;
	endtask
endmodule

// ===== tb_top.sv
// register-level bench of the infrared port control block
// assumes the link model on the event side and an axi4-lite master here
`timescale 1ns/1ps
`include "irda_ctrl_defines.svh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin errors++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top import irda_ctrl_pkg::*; ;
	logic CLK_SYS, RST, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [31:0] awaddr, wdata, araddr, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, resp;
	logic [7:0] d;
	logic [7:0] codes [8] = '{8'hE0, 8'hE4, 8'hE8, 8'hEC, 8'hF0, 8'hF4, 8'h80, 8'h7F};
	ir_events_type ev;
	logic baud, txd, rxw, txw, irpin, dreq, dtx, adv, lpb, dtr, fer, b;
	logic [5:0] rx_fill;
	logic [4:0] txthr;
	logic [3:0] rxthr;
	logic [2:0] mode;
	logic [15:0] div;
	logic [1:0] s4;
	int errors = 0;
	int num_checks = 0;
	infrared_uart_advanced_control DUT (.CLK_SYS(CLK_SYS), .RST(RST),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.EVENTS(ev), .TX_FILL_LEVEL(6'h09), .RX_FILL_LEVEL(rx_fill), .BAUD_CLOCK(baud),
		.TX_SERIAL_DATA(txd), .RX_DMA_WANT(rxw), .TX_DMA_WANT(txw), .IR_TX_PIN(irpin),
		.DTR_PIN(dtr), .DMA_REQUEST(dreq), .DMA_SERVES_TX(dtx), .TX_DMA_THRESHOLD(txthr),
		.RX_DMA_THRESHOLD(rxthr), .ADVANCED_MODE(adv), .MODE_CODE(mode),
		.LOOPBACK_ACTIVE(lpb), .FRAME_END_REQUEST(fer), .DIVISOR(div), .SET4_CONTROL(s4));
	ir_link_model link (.clk(CLK_SYS), .rst(RST), .events(ev), .baud_clock(baud),
		.serial_data(txd), .rx_want(rxw), .tx_want(txw));
	initial begin
		CLK_SYS = 1'b0;
		forever #2.5 CLK_SYS = ~CLK_SYS;
	end
	task final_report;
		if (errors == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task axw(input logic [31:0] a, input logic [7:0] v);
		@(posedge CLK_SYS);
		awaddr <= a;
		wdata <= {24'h000000, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge CLK_SYS);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask
	task axr(input logic [31:0] a);
		@(posedge CLK_SYS);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge CLK_SYS);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata[7:0];
		resp = rresp;
		rready <= 1'b0;
	endtask
	task wr(input logic [2:0] i, input logic [7:0] v);
		axw({27'h0000000, i, 2'h0}, v);
	endtask
	task rc(input logic [2:0] i, input logic [7:0] e);
		axr({27'h0000000, i, 2'h0});
		`CHK(d, e)
	endtask
	initial begin
		repeat (20000) @(posedge CLK_SYS);
		errors++;
		final_report;
	end
	initial begin
		RST = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, wdata, araddr} = '0;
		wstrb = 4'hF;
		rx_fill = 6'h00;
		repeat (6) @(posedge CLK_SYS);
		RST <= 1'b0;
		rc(3'h3, `SET2_BANK_READ);
		rc(3'h2, 8'h00);
		rc(3'h6, 8'h09);
		wr(3'h2, 8'h8D);
		wr(3'h0, 8'h34);
		wr(3'h1, 8'h12);
		`CHK(div, 16'h1234)
		`CHK(adv, 1'b1)
		`CHK(dtx, 1'b1)
		`CHK(txthr, `TX_THR_HIGH_16)
		`CHK(rxthr, `RX_THR_HIGH)
		repeat (4) begin
			b = baud;
			@(posedge CLK_SYS);
			`CHK(dtr, b)
		end
		// fir then remote mode, pio transfers
		wr(3'h3, 8'h00);
		wr(3'h4, 8'hA0);
		`CHK(mode, `MODE_FIR)
		link.hold(10'h024);
		link.fire(10'h302);
		rc(3'h7, 8'hE3);
		rc(3'h7, 8'h62);
		wr(3'h7, 8'h40);
		rc(3'h7, 8'h22);
		wr(3'h7, 8'h08);
		`CHK(fer, 1'b1)
		link.fire(10'h100);
		rc(3'h7, 8'h2A);
		link.fire(10'h040);
		rc(3'h7, 8'h22);
		`CHK(fer, 1'b0)
		link.fire(10'h010);
		rc(3'h7, 8'h32);
		wr(3'h4, 8'hC0);
		link.fire(10'h008);
		rc(3'h7, 8'h32);
		rc(3'h7, 8'h22);
		// dma mode, frame end request kept zero
		wr(3'h4, 8'hA4);
		`CHK(dreq, 1'b1)
		repeat (2099) @(posedge CLK_SYS);
		`CHK(dreq, 1'b1)
		@(posedge CLK_SYS);
		`CHK(dreq, 1'b0)
		wr(3'h3, `BANK_CODE_SET2);
		wr(3'h2, 8'h8F);
		`CHK(dreq, 1'b1)
		// set 4 control bits, then legacy divisor access
		wr(3'h3, `BANK_CODE_SET4);
		wr(3'h3, 8'h8C);
		`CHK(s4, 2'h3)
		rc(3'h0, 8'h34);
		`CHK(adv, 1'b0)
		`CHK(mode, 3'h0)
		`CHK(s4, 2'h0)
		wr(3'h7, 8'h5A);
		rc(3'h7, 8'h5A);
		// fallback disabled
		wr(3'h3, `BANK_CODE_SET2);
		wr(3'h4, 8'h80);
		wr(3'h2, 8'h01);
		wr(3'h3, 8'h80);
		rc(3'h0, 8'h34);
		`CHK(adv, 1'b1)
		wr(3'h3, `BANK_CODE_SET2);
		wr(3'h2, 8'h10);
		@(posedge CLK_SYS);
		`CHK(lpb, 1'b1)
		`CHK(irpin, 1'b0)
		wr(3'h2, 8'h00);
		rx_fill <= 6'h15;
		for (int k = 0; k < 8; k++) begin
			wr(3'h3, codes[k]);
			rc(3'h7, k == 0 ? 8'h15 : (k > 5 ? 8'h5A : 8'h00));
		end
		axw(32'h00000040, 8'h00);
		`CHK(resp, `RESP_SLVERR)
		axr(32'h00000044);
		`CHK(resp, `RESP_SLVERR)
		final_report;
	end
endmodule
bind infrared_uart_advanced_control irda_ctrl_chk u_chk (.CLK_SYS(CLK_SYS), .RST(RST),
	.S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
	.S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
	.S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
	.S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
	.S_AXI_RREADY(S_AXI_RREADY), .TX_SERIAL_DATA(TX_SERIAL_DATA), .IR_TX_PIN(IR_TX_PIN),
	.LOOPBACK_ACTIVE(LOOPBACK_ACTIVE), .DMA_REQUEST(DMA_REQUEST), .ADVANCED_MODE(ADVANCED_MODE),
	.TX_DMA_THRESHOLD(TX_DMA_THRESHOLD), .RX_DMA_THRESHOLD(RX_DMA_THRESHOLD));
